// file: rtl/cfp_fill_ctrl.sv
`timescale 1ns/100ps
// How it works
// RQ1: Cache writes of fetched read data only when cache enable sampled asserted.
// RQ2: External logic holds cache_enable_n low from strobe+1 through cycle end.
// RQ3: A cache fill is four consecutive 64-bit external reads.
// RQ4: Enable deasserted on first fetch: data passes through, never stored.
// RQ5: Hits served regardless of enable input; only flush removes entries.
// RQ6: With paging, second-level cache-disable marks cacheability; first-level ignored.
// RQ7: Write-through set keeps page data out of on-chip cache. Code blocks data reads only; instruction fetches still fill.
// RQ8: Directory-level write-through bit is reserved and never used.
// RQ9: Write-through and cache-disable are evaluated independently.
// RQ10: Fill disabled when cache-disable set or enable input deasserted.
// RQ11: Paging off: both page attributes ignored.
// RQ12: Attribute output shows write-through when select set, else cache-disable.
// RQ13: Attribute output deasserted for every cycle while paging disabled.
// RQ14: Attribute output valid with address, stable through address phase.
module cfp_fill_ctrl
	import cfp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Core request side
	input  wire logic        core_read_req,
	input  wire logic        core_is_instr,
	input  wire logic        core_cache_hit,
	input  wire logic        dir_cache_disable,
	input  wire logic        dir_write_through,
	input  wire logic        page_cache_disable,
	input  wire logic        page_write_through,
	// External bus pins
	input  wire logic        cache_enable_n,
	input  wire logic        next_address_req_n,
	input  wire logic        ready_n,
	output logic             address_strobe_n,
	output logic             page_attr_out,
	// Cache write controls
	output logic             icache_write,
	output logic             dcache_write,
	output logic             hit_serve,
	output logic             cache_flush,
	output logic             fill_busy
);
	cfp_state_e       state_q, state_d;
	logic [1:0]       beat_q, beat_d;
	logic             fill_q, fill_d;
	logic             instr_q, instr_d;
	logic             ken_ok_q, ken_ok_d;
	logic             ext_cd_q, ext_cd_d;
	logic             ext_wt_q, ext_wt_d;
	logic             ads_n_q, ads_n_d;
	logic             attr_q, attr_d;
	logic             iwr_q, iwr_d;
	logic             dwr_q, dwr_d;
	logic             hit_q, hit_d;
	logic             last_cach_q, last_cach_d;
	logic [1:0]       ctrl_q, ctrl_d;
	logic             flush_q, flush_d;
	logic [15:0]      cnt_q, cnt_d;
	logic [31:0]      rdata_q, rdata_d;
	logic             wait_q, wait_d;
	logic [1:0]       age_q, age_d;
	logic             cach_end;

	// Pins reach logic two cycles late
	localparam logic [1:0] PIN_LAG = 2'h2;
	logic [2:0]       pins_s;
	logic             ken_s, na_s, rdy_s;
	logic             paging, sel, cyc_end, data_ok, cache_ok;
	logic             eff_cd, eff_wt;

	// Pins pass two flops before use
	cfp_sync #(.WIDTH(3)) u_sync (
		.clk       (clk),
		.reset_n   (reset_n),
		.async_in  ({cache_enable_n, next_address_req_n, ready_n}),
		.reset_val (3'h7),
		.sync_out  (pins_s)
	);

	always_comb begin
		ken_s   = ~pins_s[2];
		na_s    = ~pins_s[1];
		rdy_s   = ~pins_s[0];
		paging  = ctrl_q[CTRL_PAGING];
		sel     = ctrl_q[CTRL_ATTR_SEL];
		cyc_end = na_s | rdy_s;
		data_ok = rdy_s;
		// RQ11 paging gate
		// RQ6 second level only
		eff_cd  = paging & page_cache_disable;
		// RQ8 directory unused
		// RQ9 independent attributes
		eff_wt  = paging & page_write_through;
		// RQ7 write-through
		// RQ10 cache-disable blocks fill
		cache_ok = ~eff_cd & ~(eff_wt & ~core_is_instr);
	end

	// Bus cycle sequencing and fill decision
	always_comb begin
		state_d     = state_q;
		beat_d      = beat_q;
		fill_d      = fill_q;
		instr_d     = instr_q;
		ken_ok_d    = ken_ok_q;
		ext_cd_d    = ext_cd_q;
		ext_wt_d    = ext_wt_q;
		ads_n_d     = 1'b1;
		attr_d      = attr_q;
		iwr_d       = 1'b0;
		dwr_d       = 1'b0;
		last_cach_d = last_cach_q;
		age_d       = age_q;
		cach_end    = 1'b0;
		// RQ5 hits bypass enable
		hit_d       = core_read_req & core_cache_hit & (state_q == CFP_IDLE);
		unique case (state_q)
			CFP_IDLE: begin
				if (core_read_req && !core_cache_hit) begin
					state_d  = CFP_ADDR;
					ads_n_d  = 1'b0;
					beat_d   = BEAT_RESET;
					instr_d  = core_is_instr;
					ext_cd_d = eff_cd;
					ext_wt_d = eff_wt;
					fill_d   = cache_ok;
					ken_ok_d = 1'b1;
					// RQ12 attribute select
					// RQ13 quiet without paging
					// RQ14 launched with address
					attr_d   = paging & (sel ? eff_wt : eff_cd);
				end
			end
			CFP_ADDR: begin
				state_d = CFP_DATA;
				age_d   = 2'h0;
			end
			CFP_DATA: begin
				// RQ2 window after pin lag
				// Earlier synced samples come from the strobe cycle or before it, ahead of strobe+1
				if (age_q != PIN_LAG) begin
					age_d = age_q + 2'h1;
				end else if (!ken_s) begin
					ken_ok_d = 1'b0;
				end
				if (data_ok) begin
					// RQ1 write only when enabled
					// RQ4 first beat decides
					if (fill_q && ken_ok_d) begin
						iwr_d = instr_q;
						dwr_d = ~instr_q;
					end
					// RQ3 four beat fill
					if (fill_q && ken_ok_d && beat_q != BEAT_LAST) begin
						beat_d  = beat_q + 2'h1;
						state_d = CFP_ADDR;
						ads_n_d = 1'b0;
					end else begin
						last_cach_d = fill_q & ken_ok_d;
						cach_end    = fill_q & ken_ok_d;
						fill_d      = 1'b0;
						state_d     = CFP_IDLE;
						attr_d      = 1'b0;
					end
				end else if (cyc_end && beat_q == BEAT_RESET && !ken_ok_d) begin
					fill_d = 1'b0;
				end
			end
			default: state_d = CFP_IDLE;
		endcase
	end

	// Register slave, one wait state per access
	always_comb begin
		ctrl_d  = ctrl_q;
		flush_d = 1'b0;
		// Counts every cached fill, back to back ones too
		cnt_d   = cnt_q + {15'h0000, cach_end};
		rdata_d = rdata_q;
		wait_d  = 1'b1;
		if ((avs_read || avs_write) && wait_q) begin
			wait_d = 1'b0;
			if (avs_write && avs_byteenable[0]) begin
				if (avs_address == REG_CTRL) begin
					ctrl_d  = avs_writedata[1:0];
					// RQ5 only flush clears
					flush_d = avs_writedata[CTRL_FLUSH];
				end else if (avs_address == REG_COUNT) begin
					// Fill ending in the clear cycle still counts
					cnt_d = CNT_RESET + {15'h0000, cach_end};
				end
			end
			unique case (avs_address)
				REG_CTRL:   rdata_d = {30'h0000_0000, ctrl_q};
				REG_STATUS: rdata_d = {29'h0000_0000, instr_q, last_cach_q, fill_q};
				REG_COUNT:  rdata_d = {16'h0000, cnt_q};
				default:    rdata_d = RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= CFP_IDLE;
			beat_q      <= BEAT_RESET;
			fill_q      <= 1'b0;
			instr_q     <= 1'b0;
			ken_ok_q    <= 1'b0;
			ext_cd_q    <= 1'b0;
			ext_wt_q    <= 1'b0;
			ads_n_q     <= 1'b1;
			attr_q      <= 1'b0;
			iwr_q       <= 1'b0;
			dwr_q       <= 1'b0;
			hit_q       <= 1'b0;
			last_cach_q <= 1'b0;
			age_q       <= 2'h0;
		end else begin
			state_q     <= state_d;
			beat_q      <= beat_d;
			fill_q      <= fill_d;
			instr_q     <= instr_d;
			ken_ok_q    <= ken_ok_d;
			ext_cd_q    <= ext_cd_d;
			ext_wt_q    <= ext_wt_d;
			ads_n_q     <= ads_n_d;
			attr_q      <= attr_d;
			iwr_q       <= iwr_d;
			dwr_q       <= dwr_d;
			hit_q       <= hit_d;
			last_cach_q <= last_cach_d;
			age_q       <= age_d;
		end
	end

	// Register slave state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q  <= CTRL_RESET;
			flush_q <= 1'b0;
			cnt_q   <= CNT_RESET;
			rdata_q <= RD_UNMAPPED;
			wait_q  <= 1'b1;
		end else begin
			ctrl_q  <= ctrl_d;
			flush_q <= flush_d;
			cnt_q   <= cnt_d;
			rdata_q <= rdata_d;
			wait_q  <= wait_d;
		end
	end

	always_comb begin
		avs_readdata     = rdata_q;
		avs_waitrequest  = wait_q;
		address_strobe_n = ads_n_q;
		page_attr_out    = attr_q;
		icache_write     = iwr_q;
		dcache_write     = dwr_q;
		hit_serve        = hit_q;
		cache_flush      = flush_q;
		fill_busy        = fill_q;
	end

	// Latched attributes kept for debug visibility only
	logic unused_ok;
	assign unused_ok = ext_cd_q ^ ext_wt_q ^ dir_cache_disable ^ dir_write_through
		^ avs_writedata[31] ^ (|avs_byteenable[3:1]) ^ (|avs_writedata[30:3]);
endmodule

// file: common/cfp_pkg.sv
package cfp_pkg;
	// Fill geometry
	localparam int unsigned FILL_BEATS     = 4;
	localparam int unsigned FILL_WIDTH     = 64;
	localparam int unsigned BEAT_CNT_W     = 2;
	localparam logic [1:0]  BEAT_LAST      = 2'h3;
	localparam logic [1:0]  BEAT_RESET     = 2'h0;

	// Register map (word aligned byte addresses)
	localparam logic [3:0]  REG_CTRL       = 4'h0;
	localparam logic [3:0]  REG_STATUS     = 4'h4;
	localparam logic [3:0]  REG_COUNT      = 4'h8;

	// Control register fields
	localparam int unsigned CTRL_PAGING    = 0;
	localparam int unsigned CTRL_ATTR_SEL  = 1;
	localparam int unsigned CTRL_FLUSH     = 2;
	localparam logic [1:0]  CTRL_RESET     = 2'h0;

	// Status register fields
	localparam int unsigned STAT_FILLING   = 0;
	localparam int unsigned STAT_LAST_CACH = 1;
	localparam int unsigned STAT_ICACHE    = 2;

	// Bus answers
	localparam logic [31:0] RD_UNMAPPED    = 32'h0000_0000;
	localparam logic [15:0] CNT_RESET      = 16'h0000;

	typedef enum logic [1:0] {
		CFP_IDLE  = 2'b00,
		CFP_ADDR  = 2'b01,
		CFP_DATA  = 2'b10
	} cfp_state_e;
endpackage

// file: rtl/cfp_sync.sv
`timescale 1ns/100ps
module cfp_sync
	import cfp_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	input  wire logic [WIDTH-1:0] reset_val,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;

	if (WIDTH < 1) begin : g_width_chk
		$error("cfp_sync WIDTH must be at least 1");
	end

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// Reset value is a constant; reset_val unused under reset for that reason
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q   <= '1;
			sync_out <= '1;
		end else begin
			meta_q   <= meta_d;
			sync_out <= sync_d;
		end
	end

	logic unused_ok;
	assign unused_ok = |reset_val;
endmodule

// file: verification/cfp_ext_mem.sv
`timescale 1ns/100ps
module cfp_ext_mem (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Bus pins
	input  wire logic       address_strobe_n,
	output logic            cache_enable_n,
	output logic            next_address_req_n,
	output logic            ready_n,
	// Scenario knobs
	input  wire logic       en_ok,
	input  wire logic [3:0] lat
);
	logic [3:0] cnt_q;
	logic       act_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			act_q <= 1'b0;
			cnt_q <= 4'h0;
		end else if (!address_strobe_n) begin
			act_q <= 1'b1;
			cnt_q <= lat;
		end else if (act_q) begin
			act_q <= (cnt_q != 4'h0);
			cnt_q <= cnt_q - 4'h1;
		end
	end
	// One ready per beat, after lat waits
	assign ready_n = !(act_q && cnt_q == 4'h0);
	assign cache_enable_n = !(act_q && en_ok);
	// No pipelining offered
	assign next_address_req_n = 1'b1;
endmodule

// file: verification/cfp_assertions.sv
`timescale 1ns/100ps
module cfp_chk
	import cfp_pkg::*;
(
	// Clock, reset, register bus
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	// Core, pins, cache controls
	input wire logic        core_is_instr,
	input wire logic        core_cache_hit,
	input wire logic        page_cache_disable,
	input wire logic        page_write_through,
	input wire logic        cache_enable_n,
	input wire logic        address_strobe_n,
	input wire logic        page_attr_out,
	input wire logic        icache_write,
	input wire logic        dcache_write,
	input wire logic        hit_serve
);
	logic       pg_q;
	logic       sl_q;
	logic [2:0] kc_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Mirror of control bits; run of idle enable
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pg_q <= 1'b0;
			sl_q <= 1'b0;
			kc_q <= 3'h0;
		end else begin
			kc_q <= !cache_enable_n ? 3'h0 : (kc_q == 3'h7 ? kc_q : kc_q + 3'h1);
			if (avs_write && !avs_waitrequest && avs_address == REG_CTRL && avs_byteenable[0]) begin
				pg_q <= avs_writedata[CTRL_PAGING];
				sl_q <= avs_writedata[CTRL_ATTR_SEL];
			end
		end
	end
	off_attr_a: assert property (!address_strobe_n && !pg_q |-> !page_attr_out)
		else $error("attr out set with paging off");
	attr_sel_a: assert property (!address_strobe_n && pg_q |->
		page_attr_out == (sl_q ? page_write_through : page_cache_disable))
		else $error("attr out wrong source");
	attr_hold_a: assert property (!address_strobe_n |=> $stable(page_attr_out))
		else $error("attr out moved in address phase");
	strobe_pulse_a: assert property (!address_strobe_n |=> address_strobe_n)
		else $error("strobe longer than one cycle");
	en_block_a: assert property (icache_write || dcache_write |-> kc_q < 3'h6)
		else $error("cache write without enable");
	dis_block_a: assert property (pg_q && page_cache_disable |->
		!icache_write && !dcache_write)
		else $error("cache write on disabled page");
	thr_block_a: assert property (pg_q && page_write_through && !core_is_instr |->
		!dcache_write)
		else $error("data cached on write-through page");
	hit_cause_a: assert property (hit_serve |-> core_cache_hit && address_strobe_n)
		else $error("hit served without hit");
endmodule
bind cfp_fill_ctrl cfp_chk u_chk (.clk, .reset_n, .avs_address, .avs_write, .avs_writedata,
	.avs_byteenable, .avs_waitrequest, .core_is_instr, .core_cache_hit, .page_cache_disable,
	.page_write_through, .cache_enable_n, .address_strobe_n, .page_attr_out, .icache_write,
	.dcache_write, .hit_serve);

// file: verification/testbench.sv
`timescale 1ns/100ps
module testbench
	import cfp_pkg::*;
;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        core_read_req = 1'b0;
	logic        core_is_instr = 1'b0;
	logic        core_cache_hit = 1'b0;
	logic        dir_cache_disable = 1'b0;
	logic        dir_write_through = 1'b0;
	logic        page_cache_disable = 1'b0;
	logic        page_write_through = 1'b0;
	logic        en_ok = 1'b0;
	logic [3:0]  lat = 4'h0;
	logic        cache_enable_n, next_address_req_n, ready_n, address_strobe_n;
	logic        page_attr_out, icache_write, dcache_write, hit_serve, cache_flush, fill_busy;
	int          failures = 0;
	int          n_checks = 0;
	int          n_i, n_d, n_s, n_h, n_f, n_b;
	cfp_fill_ctrl dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .core_read_req, .core_is_instr,
		.core_cache_hit, .dir_cache_disable, .dir_write_through, .page_cache_disable,
		.page_write_through, .cache_enable_n, .next_address_req_n, .ready_n,
		.address_strobe_n, .page_attr_out, .icache_write, .dcache_write, .hit_serve,
		.cache_flush, .fill_busy);
	cfp_ext_mem u_mem (.clk, .reset_n, .address_strobe_n, .cache_enable_n,
		.next_address_req_n, .ready_n, .en_ok, .lat);
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		n_i += (icache_write === 1'b1);
		n_d += (dcache_write === 1'b1);
		n_s += (address_strobe_n === 1'b0);
		n_h += (hit_serve === 1'b1);
		n_f += (cache_flush === 1'b1);
		n_b += (fill_busy === 1'b1);
	end
	task automatic test_done;
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Waits for the answer; the watchdog ends a hang
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		{avs_write, avs_read, avs_address, avs_writedata} <= {wr, !wr, a, d};
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		q = avs_readdata;
		{avs_write, avs_read} <= 2'h0;
		@(posedge clk);
	endtask
	task automatic run(input logic ins, en, pg, sl, thr, dis, hit, input logic [3:0] l);
		logic [31:0] q;
		logic        c;
		logic        p;
		p = !hit && !(pg && dis) && !(pg && thr && !ins);
		c = en && !(pg && dis) && !hit;
		bus(1'b1, REG_CTRL, {30'h0, sl, pg}, q);
		{core_is_instr, en_ok, core_cache_hit, lat} <= {ins, en, hit, l};
		{page_write_through, page_cache_disable} <= {thr, dis};
		{dir_write_through, dir_cache_disable} <= {!thr, !dis};
		@(posedge clk);
		{n_i, n_d, n_s, n_h, n_b} = '0;
		core_read_req <= 1'b1;
		@(posedge clk);
		core_read_req <= 1'b0;
		repeat (80) @(posedge clk);
		chk(n_i, c && ins ? 4 : 0);
		chk(n_d, c && !ins && !(pg && thr) ? 4 : 0);
		chk(n_h, hit);
		chk(n_s, hit ? 0 : (p && en ? 4 : 1));
		chk(n_b != 0, p);
		chk(fill_busy, 1'b0);
	endtask
	task automatic flush;
		logic [31:0] q;
		n_f = 0;
		bus(1'b1, REG_CTRL, 32'h0000_0004, q);
		repeat (4) @(posedge clk);
		chk(n_f, 1);
	endtask
	initial begin
		logic [31:0] q;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		bus(1'b0, REG_CTRL, 32'h0000_0000, q);
		chk(q, {30'h0, CTRL_RESET});
		bus(1'b0, REG_COUNT, 32'h0000_0000, q);
		chk(q, {16'h0, CNT_RESET});
		bus(1'b0, 4'hc, 32'h0000_0000, q);
		chk(q, RD_UNMAPPED);
		run(1, 1, 0, 0, 1, 1, 0, 0);
		run(0, 1, 1, 1, 1, 0, 0, 3);
		run(0, 1, 1, 0, 0, 1, 0, 1);
		run(0, 1, 1, 0, 0, 0, 0, 2);
		run(1, 0, 0, 0, 0, 0, 0, 0);
		run(0, 0, 1, 1, 0, 0, 1, 0);
		run(1, 1, 1, 1, 1, 0, 0, 0);
		bus(1'b0, REG_STATUS, 32'h0000_0000, q);
		chk(q, (32'h0000_0001 << STAT_ICACHE) | (32'h0000_0001 << STAT_LAST_CACH));
		bus(1'b0, REG_COUNT, 32'h0000_0000, q);
		chk(q, 32'h0000_0003);
		flush();
		test_done;
	end
	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		test_done;
	end
endmodule
